// >>> rtl/smrc_pkg.sv
package smrc_pkg;

    // ==========================================
    // Register map
    localparam logic [7:0] SMRC_ADDR_CTRL = 8'h00;
    localparam logic [7:0] SMRC_ADDR_SLEEP = 8'h04;
    localparam logic [7:0] SMRC_ADDR_PORT_OUT = 8'h08;
    localparam logic [7:0] SMRC_ADDR_PORT_DIR = 8'h0C;
    localparam logic [7:0] SMRC_ADDR_PORT_PULL = 8'h10;
    localparam logic [7:0] SMRC_ADDR_PORT_IN = 8'h14;
    localparam logic [7:0] SMRC_ADDR_STATUS = 8'h18;
    localparam logic [7:0] SMRC_ADDR_IRQ_EN = 8'h1C;

    // ==========================================
    // Field positions, response codes and port width
    localparam int SMRC_CTRL_RST_DIS = 0;
    localparam int SMRC_CTRL_RPIN_OUT = 1;
    localparam int SMRC_CTRL_RPIN_DIR = 2;
    localparam int SMRC_SLEEP_GO = 2;
    localparam logic [1:0] SMRC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SMRC_RESP_SLVERR = 2'h2;
    localparam int SMRC_WIDTH = 4;

    // ==========================================
    // Timing
    localparam int SMRC_CLK_MHZ = 50;
    localparam int SMRC_RST_PULSE_NS = 2500;
    localparam int SMRC_RST_CYCLES = (SMRC_RST_PULSE_NS * SMRC_CLK_MHZ
        + 999) / 1000;
    localparam int SMRC_WAKE_SLOW = 16;
    localparam int SMRC_WAKE_FAST = 1;

    // ==========================================
    // Types
    typedef enum logic [1:0] {
        SMRC_MODE_LIGHT,
        SMRC_MODE_ADC_QUIET,
        SMRC_MODE_DEEP,
        SMRC_MODE_STANDBY
    } smrc_mode_t;

    typedef enum logic [1:0] {
        SMRC_ACTIVE,
        SMRC_SLEEPING,
        SMRC_WAKING
    } smrc_state_t;

    typedef struct packed {
        logic cpu_run;
        logic sram_run;
        logic timer_run;
        logic adc_run;
        logic comp_run;
        logic irq_run;
        logic osc_run;
    } smrc_gate_t;

    typedef struct packed {
        logic [SMRC_WIDTH-1:0] o;
        logic [SMRC_WIDTH-1:0] oe;
        logic [SMRC_WIDTH-1:0] pull;
    } smrc_port_t;

endpackage

// >>> rtl/smrc_rst_filter.sv
`timescale 1ns/1ps
module smrc_rst_filter #(
    parameter int CYCLES = 125
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Pin and reset disable
    input wire logic pin_level,
    input wire logic disable_rst,
    // Result
    output logic rst_req
);
    import smrc_pkg::*;

    typedef struct packed {
        logic [15:0] cnt;
        logic req;
    } smrc_flt_t;

    smrc_flt_t st;
    smrc_flt_t next_st;

    // ==========================================
    // Low pulse length counter
    always_comb
    begin
        next_st = st;
        if (pin_level || disable_rst)
        begin
            next_st.cnt = 16'h0000;
            next_st.req = 1'b0;
        end
        else if (st.cnt >= 16'(CYCLES))
        begin
            next_st.req = 1'b1;
        end
        else
        begin
            next_st.cnt = st.cnt + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rst_req = st.req;
endmodule

// >>> rtl/smrc_port_line.sv
`timescale 1ns/1ps
module smrc_port_line (
    // Reset
    input wire logic rst_any,
    // Settings
    input wire logic out_val,
    input wire logic dir_out,
    input wire logic pull_en,
    // Pin
    output logic pin_o,
    output logic pin_oe,
    output logic pin_pull
);
    // Reset floats the line without needing a clock
    assign pin_o = rst_any ? 1'b0 : out_val;
    assign pin_oe = rst_any ? 1'b0 : dir_out;
    assign pin_pull = rst_any ? 1'b0 : (pull_en && !dir_out);
endmodule

// >>> rtl/smrc_top.sv
`timescale 1ns/1ps
module smrc_top #(
    parameter int WIDTH = smrc_pkg::SMRC_WIDTH,
    parameter int RST_CYCLES = smrc_pkg::SMRC_RST_CYCLES
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Reset pin
    input wire logic reset_pin_i,
    output logic reset_pin_o,
    output logic reset_pin_oe,
    output logic reset_pin_pull,
    // Port lines
    input wire logic [WIDTH-1:0] port_lines_i,
    output logic [WIDTH-1:0] port_lines_o,
    output logic [WIDTH-1:0] port_lines_oe,
    output logic [WIDTH-1:0] port_lines_pull,
    // Wake sources and resets
    input wire logic [7:0] irq_lines,
    input wire logic other_rst,
    // Unit clock gates and system reset
    output smrc_pkg::smrc_gate_t gate,
    output logic sys_rst
);
    import smrc_pkg::*;

    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [2:0] ctrl;
        smrc_mode_t mode;
        logic [WIDTH-1:0] p_out;
        logic [WIDTH-1:0] p_dir;
        logic [WIDTH-1:0] p_pull;
        logic [7:0] irq_en;
        smrc_state_t state;
        logic [4:0] wake_cnt;
        smrc_gate_t gate;
    } smrc_st_t;

    smrc_st_t st;
    smrc_st_t next_st;
    logic pin_rst;
    logic rst_any;
    logic wake;
    logic wr_fire;
    logic [31:0] wmask;
    logic [31:0] status;

    // ==========================================
    // Reset pin filter
    smrc_rst_filter #(
        .CYCLES(RST_CYCLES)
    ) u_filter (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .pin_level(reset_pin_i),
        .disable_rst(st.ctrl[SMRC_CTRL_RST_DIS]),
        .rst_req(pin_rst)
    );

    // Floating is combinational so it holds with a stopped clock
    assign rst_any = !rstn || pin_rst || other_rst;
    assign sys_rst = rst_any;

    // ==========================================
    // Port lines
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_line
            smrc_port_line u_line (
                .rst_any(rst_any),
                .out_val(st.p_out[gi]),
                .dir_out(st.p_dir[gi]),
                .pull_en(st.p_pull[gi]),
                .pin_o(port_lines_o[gi]),
                .pin_oe(port_lines_oe[gi]),
                .pin_pull(port_lines_pull[gi])
            );
        end
    endgenerate

    // Reset pin as weak I/O once its reset role is off
    smrc_port_line u_rpin (
        .rst_any(!st.ctrl[SMRC_CTRL_RST_DIS] || rst_any),
        .out_val(st.ctrl[SMRC_CTRL_RPIN_OUT]),
        .dir_out(st.ctrl[SMRC_CTRL_RPIN_DIR]),
        .pull_en(1'b1),
        .pin_o(reset_pin_o),
        .pin_oe(reset_pin_oe),
        .pin_pull(reset_pin_pull)
    );

    // ==========================================
    // Bus handshakes and status word
    assign s_axi_awready = !st.aw_got && !st.bvalid;
    assign s_axi_wready = !st.w_got && !st.bvalid;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = st.rdata;
    assign gate = st.gate;
    assign wake = |(irq_lines & st.irq_en);
    assign wr_fire = (st.aw_got || s_axi_awvalid)
        && (st.w_got || s_axi_wvalid) && !st.bvalid;
    assign status = {27'h0000000, reset_pin_i, st.mode, st.state};

    always_comb
    begin
        logic [7:0] a;
        logic [31:0] d;
        logic [3:0] sb;
        a = 8'h00;
        d = 32'h00000000;
        sb = 4'h0;
        wmask = 32'h00000000;
        next_st = st;
        // Write channel
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (wr_fire)
        begin
            a = st.aw_got ? st.awaddr : s_axi_awaddr;
            d = st.w_got ? st.wdata : s_axi_wdata;
            sb = st.w_got ? st.wstrb : s_axi_wstrb;
            wmask = {{8{sb[3]}}, {8{sb[2]}}, {8{sb[1]}}, {8{sb[0]}}};
            d = (d & wmask);
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = SMRC_RESP_OKAY;
            case (a)
                SMRC_ADDR_CTRL:
                    if (sb[0]) next_st.ctrl = d[2:0];
                SMRC_ADDR_SLEEP:
                begin
                    if (sb[0]) next_st.mode = smrc_mode_t'(d[1:0]);
                    if (sb[0] && d[SMRC_SLEEP_GO]
                        && st.state == SMRC_ACTIVE)
                        next_st.state = SMRC_SLEEPING;
                end
                SMRC_ADDR_PORT_OUT:
                    if (sb[0]) next_st.p_out = d[WIDTH-1:0];
                SMRC_ADDR_PORT_DIR:
                    if (sb[0]) next_st.p_dir = d[WIDTH-1:0];
                SMRC_ADDR_PORT_PULL:
                    if (sb[0]) next_st.p_pull = d[WIDTH-1:0];
                SMRC_ADDR_IRQ_EN:
                    if (sb[0]) next_st.irq_en = d[7:0];
                default:
                    next_st.bresp = SMRC_RESP_SLVERR;
            endcase
        end
        if (st.bvalid && s_axi_bready)
        begin
            next_st.bvalid = 1'b0;
        end
        // Read channel
        if (st.rvalid && s_axi_rready)
        begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp = SMRC_RESP_OKAY;
            case (s_axi_araddr)
                SMRC_ADDR_CTRL: next_st.rdata = {29'h0, st.ctrl};
                SMRC_ADDR_SLEEP: next_st.rdata = {30'h0, st.mode};
                SMRC_ADDR_PORT_OUT: next_st.rdata = 32'(st.p_out);
                SMRC_ADDR_PORT_DIR: next_st.rdata = 32'(st.p_dir);
                SMRC_ADDR_PORT_PULL: next_st.rdata = 32'(st.p_pull);
                SMRC_ADDR_PORT_IN: next_st.rdata = 32'(port_lines_i);
                SMRC_ADDR_STATUS: next_st.rdata = status;
                SMRC_ADDR_IRQ_EN: next_st.rdata = {24'h0, st.irq_en};
                default:
                begin
                    next_st.rdata = 32'h00000000;
                    next_st.rresp = SMRC_RESP_SLVERR;
                end
            endcase
        end
        // ==========================================
        // Sleep sequencer
        case (st.state)
            SMRC_ACTIVE:
                next_st.gate = '1;
            SMRC_SLEEPING:
            begin
                next_st.gate = '0;
                case (st.mode)
                    SMRC_MODE_LIGHT:
                        next_st.gate = 7'b0111111;
                    SMRC_MODE_ADC_QUIET:
                    begin
                        next_st.gate.adc_run = 1'b1;
                        next_st.gate.irq_run = 1'b1;
                        next_st.gate.osc_run = 1'b1;
                    end
                    SMRC_MODE_DEEP:
                        next_st.gate.irq_run = 1'b1;
                    SMRC_MODE_STANDBY:
                    begin
                        next_st.gate.osc_run = 1'b1;
                        next_st.gate.irq_run = 1'b1;
                    end
                    default:
                        next_st.gate = '0;
                endcase
                if (wake)
                begin
                    next_st.state = SMRC_WAKING;
                    next_st.wake_cnt = (st.gate.osc_run)
                        ? 5'(SMRC_WAKE_FAST) : 5'(SMRC_WAKE_SLOW);
                end
            end
            SMRC_WAKING:
            begin
                next_st.gate.osc_run = 1'b1;
                if (st.wake_cnt <= 5'h01)
                    next_st.state = SMRC_ACTIVE;
                else
                    next_st.wake_cnt = st.wake_cnt - 5'h01;
            end
            default:
                next_st.state = SMRC_ACTIVE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st <= '0;
            st.gate <= '1;
        end
        else if (pin_rst || other_rst)
        begin
            st <= '0;
            st.gate <= '1;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule

// >>> testbench/smrc_chk.sv
`timescale 1ns/1ps
// ==========
// Port checks
module smrc_chk #(
    parameter int WIDTH = 4,
    parameter int RST_CYCLES = 4
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Bus replies
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins, resets and clock gates
    input wire logic reset_pin_i,
    input wire logic reset_pin_oe,
    input wire logic [WIDTH-1:0] port_lines_oe,
    input wire logic [WIDTH-1:0] port_lines_pull,
    input wire logic other_rst,
    input wire smrc_pkg::smrc_gate_t gate,
    input wire logic sys_rst
);
    import smrc_pkg::*;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    sequence s_b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    sequence s_r_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    a_b_hold: assert property (
        s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write reply dropped");
    a_r_hold: assert property (
        s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read reply dropped");
    a_float_rst: assert property (
        disable iff (1'b0) sys_rst |-> !port_lines_oe && !port_lines_pull)
        else $error("port driven in reset");
    a_pull_in: assert property (
        !(port_lines_pull & port_lines_oe))
        else $error("pull on output line");
    a_rst_cause: assert property (
        sys_rst |-> other_rst || !reset_pin_i || !$past(reset_pin_i)
        || !$past(reset_pin_i, 2))
        else $error("reset without cause");
    a_weak_io: assert property (
        reset_pin_oe && !other_rst |-> !sys_rst)
        else $error("pin reset while pin is I/O");
    a_active_all: assert property (
        gate.cpu_run |-> gate == 7'h7F)
        else $error("unit stopped while running");
    a_sleep_req: assert property (
        $fell(gate.cpu_run) |-> $past(s_axi_bvalid))
        else $error("sleep without request");
    a_irq_kept: assert property (
        !gate.cpu_run |-> gate.irq_run)
        else $error("wake logic stopped");
    a_timer_comp: assert property (
        gate.timer_run == gate.comp_run)
        else $error("timer and comparator differ");
endmodule

bind smrc_top smrc_chk #(.WIDTH(WIDTH), .RST_CYCLES(RST_CYCLES)) u_chk (
    .ref_clk, .rstn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .reset_pin_i,
    .reset_pin_oe, .port_lines_oe, .port_lines_pull, .other_rst,
    .gate, .sys_rst);

// >>> testbench/smrc_partner.sv
`timescale 1ns/1ps
// ==========
// External reset source
module smrc_partner (
    // Clock
    input wire logic ref_clk,
    // Pulse request
    input wire logic fire,
    input wire logic [7:0] len,
    // Pin
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic pin_level
);
    logic [7:0] cnt = 8'h00;
    always @(posedge ref_clk)
    begin
        if (fire)
            cnt <= len;
        else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
    end
    // Low pulse, else pull-up; driven pin wins
    assign pin_level = pin_oe ? pin_o : (cnt == 8'h00);
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import smrc_pkg::*;
    logic ref_clk, rstn, fire, other_rst;
    logic [7:0] s_axi_awaddr, s_axi_araddr, irq_lines, len;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb, port_lines_i, port_lines_o, port_lines_oe;
    logic [3:0] port_lines_pull, o, d, p;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, sys_rst;
    logic reset_pin_i, reset_pin_o, reset_pin_oe, reset_pin_pull;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [13:0] e;
    smrc_gate_t gate;
    int fail_count, total_checks, n;
    smrc_top #(.RST_CYCLES(4)) dut (
        .ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .reset_pin_i, .reset_pin_o,
        .reset_pin_oe, .reset_pin_pull, .port_lines_i, .port_lines_o,
        .port_lines_oe, .port_lines_pull, .irq_lines, .other_rst,
        .gate, .sys_rst);
    smrc_partner u_src (
        .ref_clk, .fire, .len, .pin_o(reset_pin_o),
        .pin_oe(reset_pin_oe), .pin_level(reset_pin_i));
    // ==========
    // Helpers
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
        output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'($urandom_range(1));
        tb = 1'b0;
        while (!tb)
        begin
            @(negedge ref_clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge ref_clk);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
            s_axi_bready <= !tb;
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
        output logic [1:0] r);
        logic ta, tr;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'($urandom_range(1));
        tr = 1'b0;
        while (!tr)
        begin
            @(negedge ref_clk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid && s_axi_rready;
            v = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge ref_clk);
            if (ta)
                s_axi_arvalid <= 1'b0;
            s_axi_rready <= !tr;
        end
    endtask
    // Mask and expected gates of a mode
    function automatic logic [13:0] gexp(input int m);
        case (m)
            0: gexp = {7'h7F, 7'h3F};
            1: gexp = {7'h5E, 7'h0A};
            2: gexp = {7'h7F, 7'h02};
            default: gexp = {7'h7F, 7'h03};
        endcase
    endfunction
    task automatic pulse(input logic [7:0] l);
        fire <= 1'b1;
        len <= l;
        @(posedge ref_clk);
        fire <= 1'b0;
        repeat (7) @(posedge ref_clk);
    endtask
    task automatic wrap_up;
        if (fail_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ==========
    // Tests
    initial
    begin
        {rstn, fire, other_rst, s_axi_awvalid, s_axi_wvalid} = 5'h00;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, irq_lines, len} = 32'h0;
        {s_axi_wdata, port_lines_i} = 36'h0;
        s_axi_wstrb = 4'hF;
        void'($urandom(32'hE131));
        repeat (6) @(posedge ref_clk);
        chk(port_lines_oe, 4'h0);
        chk(gate, 7'h7F);
        rstn <= 1'b1;
        repeat (8)
        begin
            {o, d, p} = 12'($urandom);
            port_lines_i <= 4'($urandom);
            wr(SMRC_ADDR_PORT_OUT, {28'h0, o}, rs);
            wr(SMRC_ADDR_PORT_DIR, {28'h0, d}, rs);
            wr(SMRC_ADDR_PORT_PULL, {28'h0, p}, rs);
            chk(rs, SMRC_RESP_OKAY);
            chk(port_lines_oe, d);
            chk(port_lines_pull, p & ~d);
            chk(port_lines_o & d, o & d);
            rd(SMRC_ADDR_PORT_IN, rv, rs);
            chk(rv[3:0], port_lines_i);
        end
        rd(8'h20, rv, rs);
        chk(rs, SMRC_RESP_SLVERR);
        wr(8'h20, 32'h1, rs);
        chk(rs, SMRC_RESP_SLVERR);
        wr(SMRC_ADDR_IRQ_EN, 32'h1, rs);
        for (int m = 0; m < 4; m++)
        begin
            wr(SMRC_ADDR_SLEEP, 32'h4 | m, rs);
            repeat (3) @(posedge ref_clk);
            e = gexp(m);
            chk(gate & e[13:7], e[6:0]);
            irq_lines <= 8'h02;
            repeat (20) @(posedge ref_clk);
            chk(gate.cpu_run, 1'b0);
            irq_lines <= 8'h01;
            for (n = 0; n < 40 && gate.cpu_run !== 1'b1; n++)
                @(posedge ref_clk);
            chk(gate, 7'h7F);
            chk(32'(n > SMRC_WAKE_SLOW), 32'(m == 2));
            irq_lines <= 8'h00;
        end
        wr(SMRC_ADDR_PORT_DIR, 32'hF, rs);
        pulse(8'd10);
        chk(sys_rst, 1'b1);
        chk(port_lines_oe, 4'h0);
        repeat (8) @(posedge ref_clk);
        wr(SMRC_ADDR_CTRL, 32'h1, rs);
        pulse(8'd10);
        chk(sys_rst, 1'b0);
        chk({reset_pin_oe, reset_pin_pull}, 2'h1);
        wr(SMRC_ADDR_CTRL, 32'h7, rs);
        chk({reset_pin_oe, reset_pin_o}, 2'h3);
        wr(SMRC_ADDR_CTRL, 32'h0, rs);
        wr(SMRC_ADDR_PORT_DIR, 32'hF, rs);
        other_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({sys_rst, port_lines_oe}, 5'h10);
        other_rst <= 1'b0;
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk({sys_rst, port_lines_oe}, 5'h10);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        wrap_up;
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        wrap_up;
    end
endmodule
